//--- dv/ispm_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module ispm_core_model #(
   parameter logic [31:0] BLOCK_RST = 32'hFFFFFFFF
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [31:0] i_block_cfg,
   input  wire logic        i_fast_irq,
   output logic      [31:0] o_block_bits,
   output logic             o_fast_seen
);
   // mask stage sits on a flop, so the block bits lag their setting by one edge
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_block_bits <= BLOCK_RST;
         o_fast_seen  <= 1'b0;
      end else begin
         o_block_bits <= i_block_cfg;
         o_fast_seen  <= i_fast_irq;
      end
   end
endmodule // ispm_core_model
`default_nettype wire

//--- dv/ispm_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch at %0t got %h exp %h", $time, a, e); end end
module ispm_top_test;
   import ispm_pkg::*;
   logic        clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, fast_seen;
   logic [31:0] src = '0, cfg = '1, awaddr = '0, wdata = '0, araddr = '0, blk;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid, nany, fast;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, pend, route, cand, d;
   int          num_errors = 0, num_checks = 0;
   always #10 clk = ~clk;
   ispm_top i_ispm_top (.i_clk(clk), .i_resetn(resetn), .i_src_req(src),
      .i_per_source_block_bits(blk), .i_awvalid(awvalid), .o_awready(awready),
      .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
      .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
      .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
      .o_source_request_latch(pend), .o_fast_path_route_select(route),
      .o_normal_candidates(cand), .o_normal_any(nany), .o_fast_irq(fast));
   ispm_core_model i_ispm_core_model (.i_clk(clk), .i_resetn(resetn), .i_block_cfg(cfg),
      .i_fast_irq(fast), .o_block_bits(blk), .o_fast_seen(fast_seen));
   task automatic final_report;
      if (num_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // waits on the answer alone; only the watchdog ends a hang
   task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= v;
      wstrb <= s;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic test_reset;
      `CHK({awready, wready, arready, bvalid, rvalid}, 5'h1C)
      rd(ADDR_SRC_LATCH);
      `CHK(d, RST_SRC_LATCH)
      `CHK(r, RESP_OKAY)
      rd(ADDR_ROUTE_SEL);
      `CHK(d, RST_ROUTE_SEL)
      `CHK({fast, nany}, 2'h0)
   endtask
   task automatic test_masked;
      src <= 32'h80000001;
      repeat (5) @(posedge clk);
      `CHK(pend, 32'h80000001)
      `CHK({cand, fast}, 33'h0)
      rd(ADDR_SRC_LATCH);
      `CHK(d, 32'h80000001)
   endtask
   task automatic test_clear;
      // bit 0 stays requested so its clear collides with a live request
      src <= 32'h00000001;
      wr(ADDR_SRC_LATCH, 32'h80000001, 4'hF);
      `CHK(pend, 32'h00000001)
      src <= 32'h0;
      wr(ADDR_SRC_LATCH, 32'h0, 4'hF);
      `CHK(pend, 32'h00000001)
      wr(ADDR_SRC_LATCH, 32'h00000001, 4'hF);
      `CHK(pend, 32'h0)
   endtask
   task automatic test_route;
      wr(ADDR_ROUTE_SEL, 32'h00000004, 4'hF);
      rd(ADDR_ROUTE_SEL);
      `CHK(d, 32'h00000004)
      cfg <= 32'h0;
      src <= 32'h00000024;
      repeat (5) @(posedge clk);
      `CHK({fast, fast_seen}, 2'h3)
      `CHK(cand, 32'h00000020)
      `CHK(nany, 1'b1)
      cfg <= 32'h00000004;
      repeat (4) @(posedge clk);
      `CHK(fast, 1'b0)
      `CHK(pend, 32'h00000024)
      src <= 32'h0;
      wr(ADDR_SRC_LATCH, 32'h00000024, 4'hF);
      `CHK({pend, nany}, 33'h0)
   endtask
   task automatic test_bus;
      wr(32'h4A000008, 32'hFFFFFFFF, 4'hF);
      `CHK(r, RESP_SLVERR)
      rd(32'h4A000008);
      `CHK({d, r}, {32'h0, RESP_SLVERR})
      wr(ADDR_ROUTE_SEL, 32'hFFFFFFFF, 4'h1);
      `CHK(route, 32'h000000FF)
      wr(ADDR_ROUTE_SEL, 32'h0, 4'hF);
      `CHK(route, 32'h0)
      // only lane one is enabled, so bit 24 must survive the clear
      src <= 32'h01000100;
      repeat (5) @(posedge clk);
      src <= 32'h0;
      wr(ADDR_SRC_LATCH, 32'h01000100, 4'h2);
      `CHK(pend, 32'h01000000)
      wr(ADDR_SRC_LATCH, 32'hFFFFFFFF, 4'hF);
      `CHK(pend, 32'h0)
   endtask
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      test_reset();
      test_masked();
      test_clear();
      test_route();
      test_bus();
      final_report();
   end
   // run needs under a hundred cycles; this leaves ample margin
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      final_report();
   end
endmodule // ispm_top_test
`undef CHK
`default_nettype wire

//--- rtl/ispm_pkg.sv
// Summary of operation
// - one sticky pending bit per source, 32 sources, set on request until cleared
// - a request sets its pending bit whatever the mask bit says
// - arbitration never touches pending bits; requests set them, software clears them
// - every set pending bit is a live request passed to mask and priority stages
// - a pending bit left set keeps requesting service like a fresh request
// - writing the pending register clears the bits written as one, others kept
// - pending register at the base address, read/write, resets to all zeros
// - converter source at bit 31 down to external line zero at bit 0
// - per-source route bit: 1 selects the fast path, 0 the normal path
// - fast-path sources never reach the normal serviced or index stages
// - route register at the next word, read/write, resets to all zeros
// - unblocked sources are forwarded; blocked sources only record their pending bit
package ispm_pkg;
   localparam int          NUM_SRC           = 32;
   localparam int          ADDR_W            = 32;
   localparam int          DATA_W            = 32;
   localparam int          STRB_W            = 4;
   localparam int          SYNC_STAGES       = 2;
   localparam logic [31:0] ADDR_SRC_LATCH    = 32'h4A000000;
   localparam logic [31:0] ADDR_ROUTE_SEL    = 32'h4A000004;
   localparam logic [31:0] RST_SRC_LATCH     = 32'h00000000;
   localparam logic [31:0] RST_ROUTE_SEL     = 32'h00000000;
   localparam logic [31:0] RST_ZERO_WORD     = 32'h00000000;
   localparam int          BIT_CONVERTER     = 31;
   localparam int          BIT_EXT_LINE_ZERO = 0;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   typedef enum {
      ISPM_SEL_NONE,
      ISPM_SEL_LATCH,
      ISPM_SEL_ROUTE
   } ispm_sel_type;
endpackage

//--- rtl/ispm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ispm_sync (
   input  wire logic                       i_clk,
   input  wire logic                       i_resetn,
   input  wire logic [ispm_pkg::NUM_SRC-1:0] i_async,
   output logic      [ispm_pkg::NUM_SRC-1:0] o_sync
);
   import ispm_pkg::*;

   typedef struct packed {
      logic [NUM_SRC-1:0] meta;
      logic [NUM_SRC-1:0] stable;
   } ispm_sync_state_type;

   ispm_sync_state_type st;
   ispm_sync_state_type next_st;

   // first stage feeds only the second one
   always_comb begin
      next_st        = st;
      next_st.meta   = i_async;
      next_st.stable = st.meta;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_sync = st.stable;
endmodule // ispm_sync
`default_nettype wire

//--- rtl/ispm_top.sv
`timescale 1ns/100ps
`default_nettype none
module ispm_top (
   input  wire logic                          i_clk,
   input  wire logic                          i_resetn,
   // source requests, bit 31 converter down to bit 0 external line zero
   input  wire logic [ispm_pkg::NUM_SRC-1:0]  i_src_req,
   // block bits from the downstream mask stage, same clock
   input  wire logic [ispm_pkg::NUM_SRC-1:0]  i_per_source_block_bits,
   // axi4-lite slave
   input  wire logic                          i_awvalid,
   output logic                               o_awready,
   input  wire logic [ispm_pkg::ADDR_W-1:0]   i_awaddr,
   input  wire logic                          i_wvalid,
   output logic                               o_wready,
   input  wire logic [ispm_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic [ispm_pkg::STRB_W-1:0]   i_wstrb,
   output logic                               o_bvalid,
   input  wire logic                          i_bready,
   output logic      [1:0]                    o_bresp,
   input  wire logic                          i_arvalid,
   output logic                               o_arready,
   input  wire logic [ispm_pkg::ADDR_W-1:0]   i_araddr,
   output logic                               o_rvalid,
   input  wire logic                          i_rready,
   output logic      [ispm_pkg::DATA_W-1:0]   o_rdata,
   output logic      [1:0]                    o_rresp,
   // downstream stages
   output logic      [ispm_pkg::NUM_SRC-1:0]  o_source_request_latch,
   output logic      [ispm_pkg::NUM_SRC-1:0]  o_fast_path_route_select,
   output logic      [ispm_pkg::NUM_SRC-1:0]  o_normal_candidates,
   output logic                               o_normal_any,
   output logic                               o_fast_irq
);
   import ispm_pkg::*;

   typedef struct packed {
      logic [NUM_SRC-1:0] pend;
      logic [NUM_SRC-1:0] mode;
      logic [NUM_SRC-1:0] norm;
      logic               norm_any;
      logic               fiq;
      logic               aw_rdy;
      logic               w_rdy;
      logic               aw_full;
      logic               w_full;
      logic [ADDR_W-1:0]  aw_addr;
      logic [DATA_W-1:0]  w_data;
      logic [STRB_W-1:0]  w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               ar_rdy;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [DATA_W-1:0]  rdata;
   } ispm_state_type;

   ispm_state_type     st;
   ispm_state_type     next_st;
   logic [NUM_SRC-1:0] s_req;
   logic [NUM_SRC-1:0] clr;
   logic [DATA_W-1:0]  lanes;
   logic               aw_hs;
   logic               w_hs;
   logic               ar_hs;
   logic               wr_go;

   // full decode; anything else answers with an error
   function automatic ispm_sel_type ispm_decode(input logic [ADDR_W-1:0] addr);
      ispm_sel_type sel;
      sel = ISPM_SEL_NONE;
      if (addr == ADDR_SRC_LATCH) begin
         sel = ISPM_SEL_LATCH;
      end else if (addr == ADDR_ROUTE_SEL) begin
         sel = ISPM_SEL_ROUTE;
      end
      return sel;
   endfunction

   function automatic logic [DATA_W-1:0] ispm_lanes(input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < STRB_W; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   // requests arrive from other domains and pins
   ispm_sync i_ispm_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  (i_src_req),
      .o_sync   (s_req)
   );

   assign aw_hs = i_awvalid & st.aw_rdy;
   assign w_hs  = i_wvalid & st.w_rdy;
   assign ar_hs = i_arvalid & st.ar_rdy;
   assign wr_go = st.aw_full & st.w_full & ~st.bvalid;
   assign lanes = ispm_lanes(st.w_strb);

   always_comb begin
      next_st = st;
      clr     = '0;
      if (aw_hs) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = i_awaddr;
      end
      if (w_hs) begin
         next_st.w_full = 1'b1;
         next_st.w_data = i_wdata;
         next_st.w_strb = i_wstrb;
      end
      if (st.bvalid && i_bready) begin
         next_st.bvalid = 1'b0;
      end
      // address and data may come in either order
      if (wr_go) begin
         next_st.aw_full = 1'b0;
         next_st.w_full  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         case (ispm_decode(st.aw_addr))
            ISPM_SEL_LATCH: begin
               clr = st.w_data & lanes;
            end
            ISPM_SEL_ROUTE: begin
               // no check for more than one fast bit, software owns that
               next_st.mode = (st.mode & ~lanes) | (st.w_data & lanes);
            end
            default: begin
               next_st.bresp = RESP_SLVERR;
            end
         endcase
      end
      next_st.aw_rdy = ~next_st.aw_full & ~next_st.bvalid;
      next_st.w_rdy  = ~next_st.w_full & ~next_st.bvalid;

      if (st.rvalid && i_rready) begin
         next_st.rvalid = 1'b0;
         next_st.ar_rdy = 1'b1;
      end
      if (ar_hs) begin
         next_st.ar_rdy = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         case (ispm_decode(i_araddr))
            ISPM_SEL_LATCH: begin
               next_st.rdata = st.pend;
            end
            ISPM_SEL_ROUTE: begin
               next_st.rdata = st.mode;
            end
            default: begin
               next_st.rdata = RST_ZERO_WORD;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      // set wins over clear so a colliding request survives
      next_st.pend = (st.pend & ~clr) | s_req;
      // the mask never gates the latch itself

      // fast-routed bits are stripped from the normal vector
      next_st.norm     = next_st.pend & ~next_st.mode & ~i_per_source_block_bits;
      next_st.norm_any = |next_st.norm;
      next_st.fiq      = |(next_st.pend & next_st.mode & ~i_per_source_block_bits);
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st        <= '0;
         st.pend   <= RST_SRC_LATCH;
         st.mode   <= RST_ROUTE_SEL;
         st.aw_rdy <= 1'b1;
         st.w_rdy  <= 1'b1;
         st.ar_rdy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign o_awready                = st.aw_rdy;
   assign o_wready                 = st.w_rdy;
   assign o_bvalid                 = st.bvalid;
   assign o_bresp                  = st.bresp;
   assign o_arready                = st.ar_rdy;
   assign o_rvalid                 = st.rvalid;
   assign o_rdata                  = st.rdata;
   assign o_rresp                  = st.rresp;
   // a set bit stays visible until cleared, so it keeps requesting
   assign o_source_request_latch   = st.pend;
   assign o_fast_path_route_select = st.mode;
   assign o_normal_candidates      = st.norm;
   assign o_normal_any             = st.norm_any;
   assign o_fast_irq               = st.fiq;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence seq_wr_ready;
      st.aw_full && st.w_full && !st.bvalid;
   endsequence

   sequence seq_wr_latch_full;
      seq_wr_ready ##0 (st.aw_addr == ADDR_SRC_LATCH) && (st.w_strb == 4'hF);
   endsequence

   sequence seq_wr_route_full;
      seq_wr_ready ##0 (st.aw_addr == ADDR_ROUTE_SEL) && (st.w_strb == 4'hF);
   endsequence

   sequence seq_both_taken;
      aw_hs && w_hs;
   endsequence

   sequence seq_wr_unmapped;
      seq_wr_ready ##0 (st.aw_addr != ADDR_SRC_LATCH) && (st.aw_addr != ADDR_ROUTE_SEL);
   endsequence

   sequence seq_wr_latch_any;
      seq_wr_ready ##0 (st.aw_addr == ADDR_SRC_LATCH);
   endsequence

   sequence seq_wr_route_any;
      seq_wr_ready ##0 (st.aw_addr == ADDR_ROUTE_SEL);
   endsequence

   chk_req_sets_pend: assert property (
      (s_req != '0) |=> ((st.pend & $past(s_req)) == $past(s_req)))
      else $error("request did not set its pending bit");

   chk_pend_no_spont: assert property (
      ##1 ((st.pend & ~$past(st.pend) & ~$past(s_req)) == '0))
      else $error("pending bit set without a request");

   chk_pend_holds: assert property (
      !wr_go |=> ((st.pend & $past(st.pend)) == $past(st.pend)))
      else $error("pending bit lost without a clear");

   chk_w1c_clears: assert property (
      seq_wr_latch_full ##0 ((s_req & st.w_data) == '0)
      |=> ((st.pend & $past(st.w_data)) == '0) && o_bvalid)
      else $error("written ones did not clear pending bits");

   chk_route_write: assert property (
      seq_wr_route_full |=> (st.mode == $past(st.w_data)) && o_bvalid)
      else $error("route register write not taken");

   chk_fiq_level: assert property (
      ##1 (o_fast_irq == |(st.pend & st.mode & ~$past(i_per_source_block_bits))))
      else $error("fast request does not match routed pending bits");

   chk_normal_vec: assert property (
      ##1 (o_normal_candidates ==
           (st.pend & ~st.mode & ~$past(i_per_source_block_bits))))
      else $error("normal vector includes fast or blocked source");

   chk_read_latch: assert property (
      (i_arvalid && o_arready && i_araddr == ADDR_SRC_LATCH)
      |=> o_rvalid && (o_rdata == $past(st.pend)) && (o_rresp == RESP_OKAY))
      else $error("pending register read returned wrong data");

   chk_read_route: assert property (
      (i_arvalid && o_arready && i_araddr == ADDR_ROUTE_SEL)
      |=> o_rvalid && (o_rdata == $past(st.mode)))
      else $error("route register read returned wrong data");

   chk_rvalid_hold: assert property (
      (o_rvalid && !i_rready) |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped before it was taken");

   chk_collide_set: assert property (
      (wr_go && (s_req & st.w_data) != '0)
      |=> ((st.pend & $past(s_req)) == $past(s_req)))
      else $error("request lost against a clear");

   chk_wr_answer: assert property (
      seq_both_taken |=> ##1 o_bvalid)
      else $error("write answer not two edges after address and data");

   chk_wr_busy: assert property (
      o_bvalid |-> !o_awready && !o_wready)
      else $error("write channel open while a response waits");

   chk_bresp_hold: assert property (
      (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped before it was taken");

   chk_wr_reopen: assert property (
      (o_bvalid && i_bready) |=> !o_bvalid && o_awready && o_wready)
      else $error("write channel not reopened after the answer");

   chk_bad_write: assert property (
      seq_wr_unmapped |=> (o_bresp == RESP_SLVERR) && $stable(st.mode))
      else $error("unmapped write not refused");

   chk_bad_read: assert property (
      (i_arvalid && o_arready && (i_araddr != ADDR_SRC_LATCH) && (i_araddr != ADDR_ROUTE_SEL))
      |=> o_rvalid && (o_rdata == RST_ZERO_WORD) && (o_rresp == RESP_SLVERR))
      else $error("unmapped read not refused");

   chk_rd_busy: assert property (
      o_rvalid |-> !o_arready)
      else $error("read address open while an answer waits");

   chk_rd_reopen: assert property (
      (o_rvalid && i_rready) |=> !o_rvalid && o_arready)
      else $error("read channel not reopened after the answer");

   chk_rresp_hold: assert property (
      (o_rvalid && !i_rready) |=> $stable(o_rresp))
      else $error("read response changed before it was taken");

   chk_latch_keeps: assert property (
      seq_wr_latch_any
      |=> (((st.pend | ($past(st.w_data) & $past(lanes))) & $past(st.pend)) == $past(st.pend)))
      else $error("pending bit cleared without a written one");

   chk_route_lanes: assert property (
      seq_wr_route_any |=> (((st.mode ^ $past(st.mode)) & ~$past(lanes)) == '0))
      else $error("route bits changed outside written lanes");

   chk_mode_stable: assert property (
      !(wr_go && (st.aw_addr == ADDR_ROUTE_SEL)) |=> $stable(st.mode))
      else $error("route register changed without a write");

   chk_fast_excluded: assert property (
      (o_normal_candidates & o_fast_path_route_select) == '0)
      else $error("fast-routed source offered on the normal path");

   chk_any_level: assert property (
      o_normal_any == (o_normal_candidates != '0))
      else $error("normal summary does not match candidates");

   chk_blocked_quiet: assert property (
      ##1 ((o_normal_candidates & $past(i_per_source_block_bits)) == '0))
      else $error("blocked source offered for service");

   chk_fast_needs_route: assert property (
      (o_fast_path_route_select == '0) |-> !o_fast_irq)
      else $error("fast request with no fast-routed source");
endmodule // ispm_top
`default_nettype wire
